// File: inc/pcg_pkg.sv
package pcg_pkg;

    // Port geometry
    localparam int PCG_LINES      = 12;
    localparam int PCG_DW         = 32;
    localparam int PCG_AW         = 8;
    localparam int PCG_SER_CH     = 4;
    localparam int PCG_CTS_BASE   = 4;
    localparam int PCG_CD_BASE    = 5;
    localparam int PCG_SER_STRIDE = 2;
    localparam int PCG_UC_LINES   = 2;

    // Register byte offsets
    localparam logic [PCG_AW-1:0] PCG_OFS_DATA = 8'h00;
    localparam logic [PCG_AW-1:0] PCG_OFS_DIR  = 8'h04;
    localparam logic [PCG_AW-1:0] PCG_OFS_PAR  = 8'h08;
    localparam logic [PCG_AW-1:0] PCG_OFS_SO   = 8'h0c;
    localparam logic [PCG_AW-1:0] PCG_OFS_EDM  = 8'h10;
    localparam logic [PCG_AW-1:0] PCG_OFS_MASK = 8'h14;
    localparam logic [PCG_AW-1:0] PCG_OFS_PEND = 8'h18;

    // Field layouts and reset values
    localparam logic [PCG_LINES-1:0] PCG_SO_DEFINED = 12'hff3;
    localparam logic [PCG_LINES-1:0] PCG_UC_SEL     = 12'h003;
    localparam logic [PCG_LINES-1:0] PCG_LINES_RST  = 12'h000;
    localparam logic [PCG_DW-1:0]    PCG_RDATA_ZERO = 32'h0000_0000;

    // AHB-Lite encodings
    localparam int         PCG_HTRANS_ACT_BIT = 1;
    localparam logic [2:0] PCG_HSIZE_WORD     = 3'h2;
    localparam logic       PCG_HRESP_OKAY     = 1'b0;

    typedef logic [PCG_LINES-1:0] pcg_line_t;

    typedef struct packed {
        pcg_line_t dir;
        pcg_line_t par;
        pcg_line_t so;
        pcg_line_t edm;
        pcg_line_t mask;
    } pcg_cfg_s;

    typedef struct packed {
        logic              en;
        logic [PCG_AW-1:0] ofs;
        logic [PCG_DW-1:0] data;
    } pcg_wr_s;

    typedef struct packed {
        logic              en;
        logic [PCG_AW-1:0] ofs;
    } pcg_rd_s;

    typedef struct packed {
        pcg_line_t out;
        pcg_line_t oe;
    } pcg_drive_s;

    typedef struct packed {
        logic [PCG_SER_CH-1:0] cts_n;
        logic [PCG_SER_CH-1:0] cd_n;
    } pcg_serial_s;

endpackage

// File: verilog/pcg_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pcg_edge_detect
    import pcg_pkg::*;
#(
    parameter int WIDTH = PCG_LINES
)
(
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Raw pins and edge selection
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] edge_mode_bits,
    // Synchronised level and one-cycle requests
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] edge_req
);

    // Stages before the history holds real pin samples
    localparam int FILL = 3;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
        logic [FILL-1:0]  warm;
    } pcg_edge_state_s;

    pcg_edge_state_s s_r;
    pcg_edge_state_s s_nxt;

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.meta   = pin_in;
        s_nxt.stable = s_r.meta;
        s_nxt.prev   = s_r.stable;
        s_nxt.warm   = {s_r.warm[FILL-2:0], 1'b1};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // One flop pair per transition gives a single pulse per change
    assign level    = s_r.stable;
    // Reset zeros in the history would fake an edge on a pin idling high
    assign edge_req = {WIDTH{s_r.warm[FILL-1]}}
                    & ((edge_mode_bits & s_r.prev & ~s_r.stable)
                    | (~edge_mode_bits & (s_r.prev ^ s_r.stable)));

endmodule

`default_nettype wire

// File: verilog/pcg_ahb_front.sv
`timescale 1ns/1ps
`default_nettype none

module pcg_ahb_front
    import pcg_pkg::*;
(
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave side
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [PCG_DW-1:0] hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Register strobes
    output pcg_wr_s                wr,
    output pcg_rd_s                rd
);

    typedef struct packed {
        logic              wr_pend;
        logic [PCG_AW-1:0] ofs;
        logic              ready;
        logic              resp;
    } pcg_ahb_state_s;

    localparam pcg_ahb_state_s PCG_AHB_RST = '{wr_pend: 1'b0, ofs: '0, ready: 1'b1, resp: PCG_HRESP_OKAY};

    pcg_ahb_state_s s_r;
    pcg_ahb_state_s s_nxt;
    logic           accept;

    assign accept = hsel & htrans[PCG_HTRANS_ACT_BIT] & hready;

    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.wr_pend = 1'b0;
        s_nxt.ready   = 1'b1;
        s_nxt.resp    = PCG_HRESP_OKAY;
        if (accept && hwrite && (hsize == PCG_HSIZE_WORD))
        begin
            s_nxt.wr_pend = 1'b1;
            s_nxt.ofs     = haddr[PCG_AW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= PCG_AHB_RST;
        else
            s_r <= s_nxt;
    end

    assign wr        = '{en: s_r.wr_pend, ofs: s_r.ofs, data: hwdata};
    assign rd        = '{en: accept & ~hwrite, ofs: haddr[PCG_AW-1:0]};
    assign hreadyout = s_r.ready;
    assign hresp     = s_r.resp;

endmodule

`default_nettype wire

// File: verilog/pcg_gpio_port.sv
// Summary of operation
// - Twelve independent I/O lines, each able to raise its own request.
// - Reset clears direction and assignment bits: all lines plain inputs.
// - Reset clears the source mask, so floating pins cannot interrupt.
// - Every word-size data write lands in the output latch, whatever the direction.
// - Plain outputs drive the latch onto the pin and read back the latch.
// - Plain inputs keep the latch off the pin and read the live pin.
// - A plain output never interrupts; its edge mode is ignored.
// - A qualifying change on a plain input sends a request upward.
// - Edge detect selects falling only or any transition.
// - Edge mode zero means any change, one means high to low.
// - Each line sets its own pending bit with fixed priority position.
// - Each line's request is gated by its own mask bit.
// - Special option on inputs four to eleven routes them to serial handshake and still interrupts.
// - Unrouted clear-to-send and carrier-detect inputs stay asserted.
// - Lines zero and one with special option request the microcode controller.
// - Assignment set selects peripheral functions; direction picks which one.
// - Routed interrupting lines stay readable through the data register.
// - No open drain: outputs are actively driven both high and low.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pcg_gpio_port
    import pcg_pkg::*;
(
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite register bus
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [PCG_DW-1:0] hwdata,
    output logic      [PCG_DW-1:0] hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Port pins
    input  wire logic [PCG_LINES-1:0] pin_in,
    output logic      [PCG_LINES-1:0] pin_out,
    output logic      [PCG_LINES-1:0] pin_oe,
    // Dedicated peripheral functions
    input  wire pcg_drive_s        periph_a,
    input  wire pcg_drive_s        periph_b,
    output logic [PCG_LINES-1:0]   periph_in,
    // Serial channel handshake inputs, active low
    output pcg_serial_s            serial_in,
    // Microcode controller requests
    output logic [PCG_UC_LINES-1:0] microcode_req,
    // Interrupt controller side
    output logic [PCG_LINES-1:0]   line_req,
    output logic [PCG_LINES-1:0]   pending_request_register,
    output logic [PCG_LINES-1:0]   pending_irq
);

    typedef struct packed {
        pcg_cfg_s                  cfg;
        pcg_line_t                 latch;
        pcg_line_t                 pending;
        pcg_line_t                 line_req;
        pcg_line_t                 pend_irq;
        pcg_line_t                 pin_out;
        pcg_line_t                 pin_oe;
        pcg_line_t                 periph_in;
        pcg_serial_s               serial;
        logic [PCG_UC_LINES-1:0]   uc_req;
        logic [PCG_DW-1:0]         hrdata;
    } pcg_top_state_s;

    pcg_top_state_s s_r;
    pcg_top_state_s s_nxt;

    pcg_wr_s   wr;
    pcg_rd_s   rd;
    pcg_line_t level;
    pcg_line_t edge_req;

    // Lines in plain input mode: assignment clear, direction clear
    function automatic pcg_line_t gp_input(input pcg_cfg_s cfg);
        gp_input = ~cfg.par & ~cfg.dir;
    endfunction

    // Plain inputs with the special option taken
    function automatic pcg_line_t routed(input pcg_cfg_s cfg);
        routed = gp_input(cfg) & cfg.so;
    endfunction

    function automatic logic [PCG_DW-1:0] zext(input pcg_line_t v);
        zext = {{(PCG_DW-PCG_LINES){1'b0}}, v};
    endfunction

    pcg_ahb_front u_front
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr        (wr),
        .rd        (rd)
    );

    pcg_edge_detect #(
        .WIDTH (PCG_LINES)
    ) u_edge
    (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .pin_in         (pin_in),
        .edge_mode_bits (s_r.cfg.edm),
        .level          (level),
        .edge_req       (edge_req)
    );

    always_comb
    begin
        pcg_line_t gp_in;
        pcg_line_t route;
        pcg_line_t int_ok;
        pcg_line_t clr;
        pcg_line_t drv_out;
        pcg_line_t readback;

        gp_in    = gp_input(s_r.cfg);
        route    = routed(s_r.cfg);
        int_ok   = '0;
        clr      = '0;
        drv_out  = '0;
        readback = '0;
        s_nxt    = s_r;

        // Register writes
        if (wr.en)
        begin
            case (wr.ofs)
                PCG_OFS_DATA:
                begin
                    s_nxt.latch = wr.data[PCG_LINES-1:0];
                end
                PCG_OFS_DIR:
                begin
                    s_nxt.cfg.dir = wr.data[PCG_LINES-1:0];
                end
                PCG_OFS_PAR:
                begin
                    s_nxt.cfg.par = wr.data[PCG_LINES-1:0];
                end
                PCG_OFS_SO:
                begin
                    s_nxt.cfg.so = wr.data[PCG_LINES-1:0] & PCG_SO_DEFINED;
                end
                PCG_OFS_EDM:
                begin
                    s_nxt.cfg.edm = wr.data[PCG_LINES-1:0];
                end
                PCG_OFS_MASK:
                begin
                    s_nxt.cfg.mask = wr.data[PCG_LINES-1:0];
                end
                PCG_OFS_PEND:
                begin
                    clr = wr.data[PCG_LINES-1:0];
                end
                default:
                begin
                    clr = '0;
                end
            endcase
        end

        // Requests only from plain inputs; microcode lines are diverted
        int_ok = edge_req & gp_in & ~(route & PCG_UC_SEL);
        // Set wins over a write-one clear in the same cycle
        s_nxt.pending  = (s_r.pending & ~clr) | int_ok;
        s_nxt.line_req = int_ok & s_r.cfg.mask;
        s_nxt.pend_irq = s_nxt.pending & s_nxt.cfg.mask;

        // Microcode controller requests from the two lowest lines
        for (int k = 0; k < PCG_UC_LINES; k++)
        begin
            s_nxt.uc_req[k] = edge_req[k] & route[k];
        end

        // Serial handshake routing, asserted low when not routed
        for (int k = 0; k < PCG_SER_CH; k++)
        begin
            s_nxt.serial.cts_n[k] = route[PCG_CTS_BASE + PCG_SER_STRIDE * k]
                                  & level[PCG_CTS_BASE + PCG_SER_STRIDE * k];
            s_nxt.serial.cd_n[k]  = route[PCG_CD_BASE + PCG_SER_STRIDE * k]
                                  & level[PCG_CD_BASE + PCG_SER_STRIDE * k];
        end

        // Pin drive: peripheral function when assigned, else latch
        for (int i = 0; i < PCG_LINES; i++)
        begin
            if (s_r.cfg.par[i])
            begin
                drv_out[i]      = s_r.cfg.dir[i] ? periph_b.out[i] : periph_a.out[i];
                s_nxt.pin_oe[i] = s_r.cfg.dir[i] ? periph_b.oe[i] : periph_a.oe[i];
            end
            else
            begin
                drv_out[i]      = s_r.latch[i];
                s_nxt.pin_oe[i] = s_r.cfg.dir[i];
            end
        end
        // Push-pull only: output value drives both levels while enabled
        s_nxt.pin_out   = drv_out;
        s_nxt.periph_in = level & s_r.cfg.par;

        // Read data registered in the address phase
        if (rd.en)
        begin
            case (rd.ofs)
                PCG_OFS_DATA:
                begin
                    readback = (~s_r.cfg.par & s_r.cfg.dir & s_r.latch)
                             | (~(~s_r.cfg.par & s_r.cfg.dir) & level);
                    s_nxt.hrdata = zext(readback);
                end
                PCG_OFS_DIR:
                begin
                    s_nxt.hrdata = zext(s_r.cfg.dir);
                end
                PCG_OFS_PAR:
                begin
                    s_nxt.hrdata = zext(s_r.cfg.par);
                end
                PCG_OFS_SO:
                begin
                    s_nxt.hrdata = zext(s_r.cfg.so);
                end
                PCG_OFS_EDM:
                begin
                    s_nxt.hrdata = zext(s_r.cfg.edm);
                end
                PCG_OFS_MASK:
                begin
                    s_nxt.hrdata = zext(s_r.cfg.mask);
                end
                PCG_OFS_PEND:
                begin
                    s_nxt.hrdata = zext(s_r.pending);
                end
                default:
                begin
                    s_nxt.hrdata = PCG_RDATA_ZERO;
                end
            endcase
        end
    end

    // Reset: all lines plain inputs, mask and options clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r          <= '0;
            s_r.cfg.mask <= PCG_LINES_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign hrdata                   = s_r.hrdata;
    assign pin_out                  = s_r.pin_out;
    assign pin_oe                   = s_r.pin_oe;
    assign periph_in                = s_r.periph_in;
    assign serial_in                = s_r.serial;
    assign microcode_req            = s_r.uc_req;
    assign line_req                 = s_r.line_req;
    assign pending_request_register = s_r.pending;
    assign pending_irq              = s_r.pend_irq;

endmodule

`default_nettype wire

// File: tb/pcg_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcg_pin_model
    import pcg_pkg::*;
(
    // Port drive
    input  wire logic [PCG_LINES-1:0] pin_out,
    input  wire logic [PCG_LINES-1:0] pin_oe,
    // Board level where nothing drives
    input  wire logic [PCG_LINES-1:0] ext_lvl,
    // Level seen at the pins
    output logic      [PCG_LINES-1:0] pin_in
);
    // Driven lines win; others show the board level
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

`default_nettype wire

// File: tb/pcg_gpio_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pcg_gpio_sva
    import pcg_pkg::*;
(
    // Clock and reset
    input wire logic                    hclk,
    input wire logic                    hresetn,
    // Watched ports
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic [PCG_LINES-1:0]    pin_in,
    input wire logic [PCG_LINES-1:0]    periph_in,
    input wire pcg_serial_s             serial_in,
    input wire logic [PCG_UC_LINES-1:0] microcode_req,
    input wire logic [PCG_LINES-1:0]    line_req,
    input wire logic [PCG_LINES-1:0]    pending_request_register,
    input wire logic [PCG_LINES-1:0]    pending_irq
);
    pcg_line_t d1, d2, d3, d4, d5;
    pcg_line_t chg, hi;

    // Pin history, cleared like the synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {d1, d2, d3, d4, d5} <= '0;
        end
        else
        begin
            {d1, d2, d3, d4, d5} <= {pin_in, d1, d2, d3, d4};
        end
    end

    assign chg = (d2 ^ d3) | (d3 ^ d4) | (d4 ^ d5);
    assign hi  = d2 | d3 | d4;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_req_single: assert property (line_req != 0 |=> (line_req & $past(line_req)) == 0)
        else $error("line request longer than one cycle");
    a_req_cause: assert property ((line_req & ~chg) == 0)
        else $error("line request without pin change");
    a_pend_cause: assert property ((pending_request_register & ~$past(pending_request_register) & ~chg) == 0)
        else $error("pending bit set without pin change");
    a_req_pend: assert property ((line_req & ~pending_request_register) == 0)
        else $error("line request without pending bit");
    a_irq_mask: assert property ((pending_irq & ~pending_request_register) == 0)
        else $error("irq without pending bit");
    a_uc_only: assert property ((microcode_req & line_req[PCG_UC_LINES-1:0]) == 0)
        else $error("microcode and line request together");
    a_uc_cause: assert property ((microcode_req & ~chg[PCG_UC_LINES-1:0]) == 0)
        else $error("microcode request without pin change");
    a_serial_lvl: assert property ((serial_in.cts_n & ~{hi[10], hi[8], hi[6], hi[4]}) == 0
        && (serial_in.cd_n & ~{hi[11], hi[9], hi[7], hi[5]}) == 0)
        else $error("serial input high while pin low");
    a_periph_lvl: assert property ((periph_in & ~hi) == 0)
        else $error("peripheral input high while pin low");

    c_line_req: cover property (line_req != 0);
    c_uc_req: cover property (microcode_req != 0);
    c_serial: cover property (serial_in != 0);
endmodule

bind pcg_gpio_port pcg_gpio_sva i_pcg_gpio_sva (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .hreadyout                (hreadyout),
    .hresp                    (hresp),
    .pin_in                   (pin_in),
    .periph_in                (periph_in),
    .serial_in                (serial_in),
    .microcode_req            (microcode_req),
    .line_req                 (line_req),
    .pending_request_register (pending_request_register),
    .pending_irq              (pending_irq)
);

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pcg_pkg::*;

    logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]             haddr;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [PCG_DW-1:0]       hwdata, hrdata, rdat;
    pcg_line_t               pin_in, pin_out, pin_oe, ext_lvl, periph_in, line_req, pend, pend_irq;
    pcg_drive_s              periph_a, periph_b;
    pcg_serial_s             serial_in;
    logic [PCG_UC_LINES-1:0] uc_req;
    int                      n_errors, samples_checked, n_req, n_uc, r0, u0;

    pcg_gpio_port i_pcg_gpio_port (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_a(periph_a), .periph_b(periph_b), .periph_in(periph_in), .serial_in(serial_in),
        .microcode_req(uc_req), .line_req(line_req), .pending_request_register(pend),
        .pending_irq(pend_irq)
    );

    pcg_pin_model i_pcg_pin_model (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in)
    );

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Request pulse counters
    always @(posedge hclk)
    begin
        n_req <= n_req + $countones(line_req);
        n_uc  <= n_uc + $countones(uc_req);
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [PCG_AW-1:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= PCG_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [PCG_AW-1:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [PCG_AW-1:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, rdat, exp);
    endtask

    // Counts snapshot before the wait, so pulses caused during it are seen
    task automatic idle(input int n);
        r0 = n_req;
        u0 = n_uc;
        repeat (n) @(posedge hclk);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        test_done;
    end

    initial
    begin
        {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {ext_lvl, periph_a, periph_b, n_req, n_uc} = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 8; a++) rd(PCG_AW'(a * 4), 0, "reset reg");
        chk("serial", serial_in, 0);
        chk("oe", pin_oe, 0);
        $display("test reset done");
        wr(PCG_OFS_DIR, 32'h0000_0fff);
        wr(PCG_OFS_DATA, 32'h0000_0a5c);
        idle(3);
        chk("oe", pin_oe, 32'h0000_0fff);
        chk("out", pin_out, 32'h0000_0a5c);
        rd(PCG_OFS_DATA, 32'h0000_0a5c, "data out");
        rd(PCG_OFS_PEND, 0, "pend out");
        wr(PCG_OFS_DIR, 0);
        ext_lvl <= 12'h3c6;
        wr(PCG_OFS_DATA, 32'h0000_0123);
        idle(5);
        chk("oe", pin_oe, 0);
        rd(PCG_OFS_DATA, 32'h0000_03c6, "data in");
        wr(PCG_OFS_DIR, 32'h0000_0fff);
        idle(2);
        chk("latch", pin_out, 32'h0000_0123);
        wr(PCG_OFS_DIR, 0);
        ext_lvl <= 12'h000;
        $display("test data done");
        idle(6);
        wr(PCG_OFS_PEND, 32'h0000_0fff);
        ext_lvl <= 12'hfff;
        idle(6);
        rd(PCG_OFS_PEND, 32'h0000_0fff, "pend any");
        chk("req masked", n_req - r0, 0);
        chk("serial", serial_in, 0);
        wr(PCG_OFS_MASK, 32'h0000_00ff);
        wr(PCG_OFS_EDM, 32'h0000_00f0);
        wr(PCG_OFS_PEND, 32'h0000_0fff);
        idle(1);
        ext_lvl <= 12'h000;
        idle(6);
        rd(PCG_OFS_PEND, 32'h0000_0fff, "pend fall");
        chk("irq", pend_irq, 32'h0000_00ff);
        chk("req fall", n_req - r0, 8);
        wr(PCG_OFS_PEND, 32'h0000_0fff);
        idle(1);
        ext_lvl <= 12'hfff;
        idle(6);
        rd(PCG_OFS_PEND, 32'h0000_0f0f, "pend rise");
        chk("req rise", n_req - r0, 4);
        $display("test edge done");
        wr(PCG_OFS_EDM, 0);
        wr(PCG_OFS_MASK, 32'h0000_0fff);
        wr(PCG_OFS_SO, 32'h0000_0fff);
        rd(PCG_OFS_SO, 32'h0000_0ff3, "so");
        wr(PCG_OFS_PEND, 32'h0000_0fff);
        idle(5);
        chk("serial hi", serial_in, 8'hff);
        ext_lvl <= 12'h5ac;
        idle(6);
        chk("serial", serial_in, 8'hc3);
        rd(PCG_OFS_PEND, 32'h0000_0a50, "pend so");
        chk("uc", n_uc - u0, 2);
        chk("req so", n_req - r0, 4);
        rd(PCG_OFS_DATA, 32'h0000_05ac, "data so");
        wr(PCG_OFS_SO, 0);
        idle(5);
        chk("serial off", serial_in, 0);
        $display("test special done");
        wr(PCG_OFS_PAR, 32'h0000_0fff);
        wr(PCG_OFS_DIR, 32'h0000_00f0);
        periph_a <= '{out: 12'haaa, oe: 12'hfff};
        periph_b <= '{out: 12'h0a0, oe: 12'h0f0};
        idle(6);
        wr(PCG_OFS_PEND, 32'h0000_0fff);
        periph_a <= '{out: 12'h555, oe: 12'hfff};
        idle(6);
        chk("pf out", pin_out, 32'h0000_05a5);
        chk("pf oe", pin_oe, 32'h0000_0fff);
        chk("pf in", periph_in, 32'h0000_05a5);
        rd(PCG_OFS_PEND, 0, "pend pf");
        rd(8'h20, 0, "unmapped");
        $display("test periph done");
        // Second reset with pins idling high: no false edge may follow
        ext_lvl <= 12'hfff;
        hresetn <= 1'b0;
        idle(5);
        hresetn <= 1'b1;
        idle(8);
        chk("oe", pin_oe, 0);
        rd(PCG_OFS_PAR, 0, "par reset");
        rd(PCG_OFS_MASK, 0, "mask reset");
        rd(PCG_OFS_DATA, 32'h0000_0fff, "data reset");
        rd(PCG_OFS_PEND, 0, "pend reset");
        $display("test reset again done");
        test_done;
    end
endmodule

`default_nettype wire
